// file: rtl/gyro_defines.svh
// offsets, field positions, reset values and timing counts of the rate sensor block
`ifndef GYRO_DEFINES_SVH
`define GYRO_DEFINES_SVH
// =====================================
// register offsets (seven-bit register address)
`define OFS_RATE_DIV 7'h19
`define OFS_FILTER 7'h1A
`define OFS_RANGE 7'h1B
`define OFS_FIFO_SEL 7'h23
`define OFS_IRQ_PIN 7'h37
`define OFS_IRQ_EN1 7'h38
`define OFS_IRQ_EN2 7'h39
`define OFS_IRQ_STAT 7'h3A
`define OFS_TEMP_H 7'h41
`define OFS_RX_H 7'h43
`define OFS_RY_H 7'h45
`define OFS_RZ_H 7'h47
`define OFS_USER 7'h6A
`define OFS_POWER1 7'h6B
`define OFS_CNT_H 7'h72
`define OFS_CNT_L 7'h73
`define OFS_FIFO_DATA 7'h74
`define OFS_IDENT 7'h75
// =====================================
// values
`define ID_VALUE 8'hA5
`define POWER1_RST 8'h41
`define SOFT_RST_CMD 8'h81
`define TWO_WIRE_BASE 6'h34
`define STATUS_MASK 8'h11
// =====================================
// field positions
`define BIT_SOFT_RST 7
`define BIT_SLEEP 6
`define BIT_CYCLE 5
`define BIT_STANDBY 4
`define BIT_WIRE_DIS 4
`define BIT_ACT_LOW 7
`define BIT_OPEN 6
`define BIT_LATCH 5
`define BIT_ANY_RD 4
// =====================================
// timing
`define CLK_PERIOD_NS 50
`define IRQ_PULSE_NS 50000
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS) / (`CLK_PERIOD_NS))
`endif

// file: rtl/gyro_pkg.sv
// types shared by the rate sensor block
package gyro_pkg;
  // serial frame phase, one-hot
  typedef enum logic [1:0] {
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } phase_type;
  // power modes, one-hot
  typedef enum logic [3:0] {
    PM_SLEEP = 4'b0001,
    PM_STANDBY = 4'b0010,
    PM_LOW_NOISE = 4'b0100,
    PM_LOW_POWER = 4'b1000
  } pmode_type;
endpackage

// file: rtl/pin_sync.sv
// two flip-flop synchroniser for pin inputs
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;

  // =====================================
  // two stages
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// file: rtl/sync_fifo.sv
// flip-flop fifo with valid and ready on both sides
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  // depth is a power of two, so pointers wrap by themselves
  assign in_ready_o = cnt_reg != CW'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign count_o = cnt_reg;

  // =====================================
  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end
endmodule

// file: rtl/gyro_host_config_and_readout.sv
// host register access, configuration, readout fifo and interrupt pins of the rate sensor
`include "gyro_defines.svh"

// Notes on behaviour
// R01: chip select low four-wire, high two-wire
// R02: two interrupt pins, push-pull or open-drain
// R03: two-wire address bit zero from select pin
// R04: two-wire address 1101000 or 1101001
// R05: sixteen-bit axes, four selectable rate ranges
// R06: converter rate programmable by divider
// R07: per-axis self-test bits in range register
// R08: clock source relaxation only or auto
// R09: data registers read-only, latest, always readable
// R10: fifo item selection: rate, temperature, frame sync
// R11: fifo byte counter and burst readout
// R12: pin config, latching, clearing, sources
// R13: data-ready and overflow raise status bits
// R14: temperature in data registers and fifo
// R15: four power modes from power control
// R16: power-on reset defines all control state
// R17: host keeps clock low at ramp-up
// R18: soft reset recovers the serial interface
// R19: write 0x81 to power control resets
// R20: identity valid only after soft reset
// R21: sample divider at 0x19 sets output rate
// R22: range setting written at 0x1B
// R23: filter stage written at 0x1A
// R24: four-wire host sets two-wire disable
// R25: writes to read-only registers ignored
module gyro_host_config_and_readout
  import gyro_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic chip_select_i,
  input wire logic four_wire_clock_pin_i,
  input wire logic four_wire_data_in_i,
  input wire logic address_select_pin_i,
  input wire logic frame_sync_input_i,
  output logic four_wire_data_out_o,
  output logic four_wire_data_out_oe_n_o,
  output logic two_wire_mode_o,
  output logic [6:0] two_wire_addr_o,
  // converter results
  input wire logic sample_valid_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] rate_x_i,
  input wire logic [15:0] rate_y_i,
  input wire logic [15:0] rate_z_i,
  // sensor controls
  output logic [2:0] self_test_o,
  output logic [1:0] range_setting_o,
  output logic [2:0] low_pass_filter_stage_o,
  output logic clk_auto_o,
  output logic [3:0] power_mode_o,
  // interrupt pins
  output logic irq_out_primary_o,
  output logic irq_out_primary_oe_n_o,
  output logic irq_out_secondary_o,
  output logic irq_out_secondary_oe_n_o
);
  // =====================================
  // pin synchronisers
  logic [4:0] pin_q;
  pin_sync #(.WIDTH(5), .RST_VAL(5'h10)) u_pin_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({chip_select_i, four_wire_clock_pin_i, four_wire_data_in_i,
          address_select_pin_i, frame_sync_input_i}),
    .q_o(pin_q)
  );
  wire logic cs_q = pin_q[4];     // chip select, idle high
  wire logic sclk_q = pin_q[3];   // serial clock
  wire logic din_q = pin_q[2];    // serial data in
  wire logic asel_q = pin_q[1];   // address select
  wire logic frame_q = pin_q[0];  // frame sync

  // =====================================
  // configuration state
  logic [7:0] rate_div_reg;   // sample divider
  logic [7:0] filter_reg;     // filter stage
  logic [7:0] range_reg;      // self-test and range
  logic [7:0] fifo_sel_reg;   // fifo item selection
  logic [7:0] irq_pin_reg;    // pin level, drive, latch, clear
  logic [7:0] irq_en1_reg;    // primary pin sources
  logic [7:0] irq_en2_reg;    // secondary pin sources
  logic [7:0] user_reg;       // interface control
  logic [7:0] power1_reg;     // power and clock
  logic [7:0] status_reg;     // sticky event bits
  logic soft_rst_reg;         // one-cycle soft reset
  logic ident_ok_reg;         // identity readable
  wire logic wire_dis = user_reg[`BIT_WIRE_DIS];

  // =====================================
  // serial frame engine
  phase_type phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rd_reg;
  logic [6:0] addr_reg;
  logic sclk_d_reg;
  logic dout_reg;
  logic dout_oe_n_reg;
  // clock edge seen only inside a frame
  wire logic sclk_rise = sclk_q && !sclk_d_reg && !cs_q;
  wire logic [7:0] byte_val = {shift_reg[6:0], din_q};
  wire logic byte_done = sclk_rise && bit_cnt_reg == 3'h7;
  wire logic in_cmd = phase_reg == PH_CMD;
  // the fifo data port does not advance, so bursts drain the fifo
  wire logic [6:0] next_addr = (addr_reg == `OFS_FIFO_DATA) ? addr_reg : addr_reg + 7'h01;
  wire logic [6:0] sel_addr = in_cmd ? byte_val[6:0] : next_addr;
  wire logic rd_fire = byte_done && (in_cmd ? byte_val[7] : rd_reg);
  wire logic wr_fire = byte_done && !in_cmd && !rd_reg;
  wire logic [7:0] rd_data;

  // address compare, shared by all side effects
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = a == ofs;
  endfunction

  // edge history
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_q;
    end
  end

  // frame phase; chip select high ends every frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || cs_q) begin
      phase_reg <= PH_CMD;
      rd_reg <= 1'b0;
    end else begin
      case (phase_reg)
        PH_CMD: begin
          if (byte_done) begin
            phase_reg <= PH_DATA;
            rd_reg <= byte_val[7];
          end
        end
        PH_DATA: begin
          phase_reg <= PH_DATA;
        end
        default: begin
          phase_reg <= PH_CMD;
        end
      endcase
    end
  end

  // bit shifter and burst address
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || cs_q) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      addr_reg <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_val;
      if (byte_done) begin
        addr_reg <= sel_addr; // R11
      end
    end
  end

  // read data leaves msb first, changing after each rising edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || cs_q) begin
      tx_reg <= 8'h00;
      dout_reg <= 1'b0;
    end else if (rd_fire) begin
      dout_reg <= rd_data[7];
      tx_reg <= {rd_data[6:0], 1'b0};
    end else if (sclk_rise) begin
      dout_reg <= tx_reg[7];
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // pin modes; data out released outside a frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dout_oe_n_reg <= 1'b1;
      two_wire_mode_o <= 1'b0;
      two_wire_addr_o <= {`TWO_WIRE_BASE, 1'b0};
    end else begin
      dout_oe_n_reg <= cs_q; // R01
      two_wire_mode_o <= cs_q && !wire_dis; // R01 R24
      two_wire_addr_o <= {`TWO_WIRE_BASE, asel_q}; // R03 R04
    end
  end
  assign four_wire_data_out_o = dout_reg;
  assign four_wire_data_out_oe_n_o = dout_oe_n_reg;

  // =====================================
  // register writes; data and identity have no write path
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_rst_reg) begin // R16 R18 R19
      rate_div_reg <= 8'h00;
      filter_reg <= 8'h00;
      range_reg <= 8'h00;
      fifo_sel_reg <= 8'h00;
      irq_pin_reg <= 8'h00;
      irq_en1_reg <= 8'h00;
      irq_en2_reg <= 8'h00;
      user_reg <= 8'h00;
      power1_reg <= `POWER1_RST;
    end else if (wr_fire) begin
      case (addr_reg)
        `OFS_RATE_DIV: rate_div_reg <= byte_val; // R21
        `OFS_FILTER: filter_reg <= byte_val; // R23
        `OFS_RANGE: range_reg <= byte_val; // R07 R22
        `OFS_FIFO_SEL: fifo_sel_reg <= byte_val; // R10
        `OFS_IRQ_PIN: irq_pin_reg <= byte_val; // R12
        `OFS_IRQ_EN1: irq_en1_reg <= byte_val & `STATUS_MASK;
        `OFS_IRQ_EN2: irq_en2_reg <= byte_val & `STATUS_MASK;
        `OFS_USER: user_reg <= byte_val;
        `OFS_POWER1: power1_reg <= byte_val & 8'h7F; // R15 R08
        default: ; // R25
      endcase
    end
  end

  // soft reset pulse and identity gate
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      soft_rst_reg <= 1'b0;
      ident_ok_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_fire && hit(addr_reg, `OFS_POWER1) && byte_val[`BIT_SOFT_RST]; // R19
      ident_ok_reg <= ident_ok_reg || soft_rst_reg; // R20
    end
  end

  // =====================================
  // sensor controls
  pmode_type pmode_reg;
  wire pmode_type pmode_next = power1_reg[`BIT_SLEEP] ? PM_SLEEP :
                               power1_reg[`BIT_STANDBY] ? PM_STANDBY :
                               power1_reg[`BIT_CYCLE] ? PM_LOW_POWER : PM_LOW_NOISE;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pmode_reg <= PM_SLEEP;
      self_test_o <= 3'h0;
      range_setting_o <= 2'h0;
      low_pass_filter_stage_o <= 3'h0;
      clk_auto_o <= 1'b0;
    end else begin
      pmode_reg <= pmode_next; // R15
      self_test_o <= range_reg[7:5]; // R07
      range_setting_o <= range_reg[4:3]; // R05 R22
      low_pass_filter_stage_o <= filter_reg[2:0]; // R23
      clk_auto_o <= power1_reg[2:0] != 3'h0; // R08
    end
  end
  assign power_mode_o = pmode_reg;

  // =====================================
  // output rate divider; sleep and standby stop sampling
  logic [7:0] div_cnt_reg;
  wire logic sensing = pmode_reg == PM_LOW_NOISE || pmode_reg == PM_LOW_POWER;
  wire logic div_hit = div_cnt_reg >= rate_div_reg;
  wire logic tick = sample_valid_i && sensing && div_hit;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_rst_reg) begin
      div_cnt_reg <= 8'h00;
    end else if (sample_valid_i && sensing) begin
      div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01; // R06 R21
    end
  end

  // latest results, refreshed at the output rate
  logic [15:0] temp_reg;
  logic [15:0] rx_reg;
  logic [15:0] ry_reg;
  logic [15:0] rz_reg;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      temp_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      ry_reg <= 16'h0000;
      rz_reg <= 16'h0000;
    end else if (tick) begin
      temp_reg <= temp_i; // R09 R14
      rx_reg <= rate_x_i; // R05 R09
      ry_reg <= rate_y_i;
      rz_reg <= rate_z_i;
    end
  end

  // =====================================
  // fifo item sequencer: temp, x, y, z, frame sync in that order
  logic [4:0] pend_reg;
  logic half_reg;
  wire logic [4:0] item_mask = {fifo_sel_reg[3], fifo_sel_reg[4], fifo_sel_reg[5],
                                fifo_sel_reg[6], fifo_sel_reg[7]};
  wire logic [4:0] pick = pend_reg & (~pend_reg + 5'h01);
  wire logic [15:0] item_word = ({16{pick[0]}} & temp_reg) | ({16{pick[1]}} & rx_reg) |
                                ({16{pick[2]}} & ry_reg) | ({16{pick[3]}} & rz_reg) |
                                ({16{pick[4]}} & {15'h0000, frame_q});
  // a new sample while items of the last are still pending flags overflow, whether or not the store is full
  wire logic ovf_evt = tick && pend_reg != 5'h00;
  wire logic fifo_rst_n = rst_n_i && !soft_rst_reg;
  logic stage_in_ready;
  logic stage_out_valid;
  logic stage_out_ready;
  logic [15:0] stage_data;
  logic store_in_ready;
  logic store_out_valid;
  logic [7:0] store_data;
  logic [12:0] store_cnt;
  // pop on the first clock of the byte after a fifo byte was loaded, so a frame that
  // ends right after a prefetch of the data port loses nothing
  wire logic store_pop = sclk_rise && bit_cnt_reg == 3'h0 && !in_cmd && rd_reg &&
                         hit(addr_reg, `OFS_FIFO_DATA) && store_out_valid;

  always_ff @(posedge core_clk_i) begin
    if (!fifo_rst_n) begin
      pend_reg <= 5'h00;
    end else if (tick) begin
      pend_reg <= item_mask; // R10 R14
    end else if (stage_in_ready) begin
      pend_reg <= pend_reg & ~pick;
    end
  end

  // words staged here, split into bytes high first
  sync_fifo #(.WIDTH(16), .DEPTH(4)) u_stage (
    .clk_i(core_clk_i),
    .rst_n_i(fifo_rst_n),
    .in_valid_i(pend_reg != 5'h00),
    .in_ready_o(stage_in_ready),
    .in_data_i(item_word),
    .out_valid_o(stage_out_valid),
    .out_ready_i(stage_out_ready),
    .out_data_o(stage_data),
    .count_o()
  );
  assign stage_out_ready = store_in_ready && half_reg;
  always_ff @(posedge core_clk_i) begin
    if (!fifo_rst_n) begin
      half_reg <= 1'b0;
    end else if (stage_out_valid && store_in_ready) begin
      half_reg <= !half_reg;
    end
  end

  // byte store drained by reads of the fifo data port
  sync_fifo #(.WIDTH(8), .DEPTH(4096)) u_store (
    .clk_i(core_clk_i),
    .rst_n_i(fifo_rst_n),
    .in_valid_i(stage_out_valid),
    .in_ready_o(store_in_ready),
    .in_data_i(half_reg ? stage_data[7:0] : stage_data[15:8]),
    .out_valid_o(store_out_valid),
    .out_ready_i(store_pop), // R11
    .out_data_o(store_data),
    .count_o(store_cnt)
  );

  // =====================================
  // register read mux
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case (a)
      `OFS_RATE_DIV: reg_read = rate_div_reg;
      `OFS_FILTER: reg_read = filter_reg;
      `OFS_RANGE: reg_read = range_reg;
      `OFS_FIFO_SEL: reg_read = fifo_sel_reg;
      `OFS_IRQ_PIN: reg_read = irq_pin_reg;
      `OFS_IRQ_EN1: reg_read = irq_en1_reg;
      `OFS_IRQ_EN2: reg_read = irq_en2_reg;
      `OFS_IRQ_STAT: reg_read = status_reg; // R13
      `OFS_TEMP_H: reg_read = temp_reg[15:8]; // R09
      `OFS_TEMP_H + 7'h01: reg_read = temp_reg[7:0];
      `OFS_RX_H: reg_read = rx_reg[15:8];
      `OFS_RX_H + 7'h01: reg_read = rx_reg[7:0];
      `OFS_RY_H: reg_read = ry_reg[15:8];
      `OFS_RY_H + 7'h01: reg_read = ry_reg[7:0];
      `OFS_RZ_H: reg_read = rz_reg[15:8];
      `OFS_RZ_H + 7'h01: reg_read = rz_reg[7:0];
      `OFS_USER: reg_read = user_reg;
      `OFS_POWER1: reg_read = power1_reg;
      `OFS_CNT_H: reg_read = {3'h0, store_cnt[12:8]}; // R11
      `OFS_CNT_L: reg_read = store_cnt[7:0];
      `OFS_FIFO_DATA: reg_read = store_out_valid ? store_data : 8'h00;
      `OFS_IDENT: reg_read = ident_ok_reg ? `ID_VALUE : 8'h00; // R20
      default: reg_read = 8'h00;
    endcase
  endfunction
  assign rd_data = reg_read(sel_addr);

  // =====================================
  // sticky status: a set in the clearing cycle survives
  wire logic [7:0] set_vec = {3'h0, ovf_evt, 3'h0, tick};
  wire logic st_clr = rd_fire && (irq_pin_reg[`BIT_ANY_RD] || hit(sel_addr, `OFS_IRQ_STAT));
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || soft_rst_reg) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= ((st_clr ? 8'h00 : status_reg) | set_vec) & `STATUS_MASK; // R12 R13
    end
  end

  // two pins, latched level or fixed-width pulse
  wire logic [1:0] irq_pin_w;
  wire logic [1:0] irq_oe_n_w;
  for (genvar i = 0; i < 2; i++) begin : g_irq
    wire logic [7:0] en = (i == 0) ? irq_en1_reg : irq_en2_reg;
    logic [9:0] pulse_reg;
    logic pin_reg;
    logic oe_n_reg;
    wire logic act = irq_pin_reg[`BIT_LATCH] ? (status_reg & en) != 8'h00 : pulse_reg != 10'h000;
    wire logic lvl = act ^ irq_pin_reg[`BIT_ACT_LOW];
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        pulse_reg <= 10'h000;
      end else if ((set_vec & en) != 8'h00) begin
        pulse_reg <= 10'(`IRQ_PULSE_CYC); // R12
      end else if (pulse_reg != 10'h000) begin
        pulse_reg <= pulse_reg - 10'h001;
      end
    end
    // open-drain only pulls low, push-pull always drives
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        pin_reg <= 1'b0;
        oe_n_reg <= 1'b1;
      end else begin
        pin_reg <= lvl; // R02
        oe_n_reg <= irq_pin_reg[`BIT_OPEN] && lvl; // R02
      end
    end
    assign irq_pin_w[i] = pin_reg;
    assign irq_oe_n_w[i] = oe_n_reg;
  end
  assign irq_out_primary_o = irq_pin_w[0];
  assign irq_out_primary_oe_n_o = irq_oe_n_w[0];
  assign irq_out_secondary_o = irq_pin_w[1];
  assign irq_out_secondary_oe_n_o = irq_oe_n_w[1];

  // =====================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence soft_wr_s;
    wr_fire && hit(addr_reg, `OFS_POWER1) && byte_val == `SOFT_RST_CMD;
  endsequence
  sequence soft_done_s;
    soft_rst_reg ##1 (ident_ok_reg && rate_div_reg == 8'h00);
  endsequence
  wire logic ev_p = tick && irq_en1_reg[0] && !irq_pin_reg[`BIT_LATCH];
  mode_pick_a: assert property (cs_q && !wire_dis |=> two_wire_mode_o) // R01
    else $error("two-wire mode not taken");
  dout_release_a: assert property (cs_q |=> four_wire_data_out_oe_n_o) // R01
    else $error("data out driven outside frame");
  addr_lsb_a: assert property (##1 two_wire_addr_o == {6'h34, $past(asel_q)}) // R04
    else $error("two-wire address wrong");
  soft_reset_a: assert property (soft_wr_s |=> soft_done_s) // R19
    else $error("soft reset not done");
  ident_gate_a: assert property (!ident_ok_reg |-> reg_read(`OFS_IDENT) == 8'h00) // R20
    else $error("identity shown before soft reset");
  data_ro_a: assert property (wr_fire && !tick |=> $stable(temp_reg) && $stable(rz_reg)) // R25
    else $error("read-only data changed by write");
  range_out_a: assert property (wr_fire && hit(addr_reg, `OFS_RANGE) && !soft_rst_reg
    |-> ##2 range_setting_o == $past(byte_val[4:3], 2)) // R22
    else $error("range not applied");
  fifo_count_a: assert property (stage_out_valid && store_in_ready && !store_pop
    |=> store_cnt == $past(store_cnt) + 13'h0001) // R11
    else $error("fifo count not advanced");
  ovf_flag_a: assert property (ovf_evt && !soft_rst_reg |=> status_reg[4]) // R13
    else $error("overflow not flagged");
  irq_pulse_a: assert property (ev_p && $stable(irq_pin_reg) |-> ##2 irq_out_primary_o
    == !irq_pin_reg[`BIT_ACT_LOW]) // R12
    else $error("interrupt pulse missing");
endmodule

// file: sim/host_model.sv
// four-wire serial master standing in for the system processor
module host_model (
  // serial pins
  output logic cs_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // idle: two-wire select high, clock held low at power-up
  initial begin
    cs_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // open a four-wire frame
  task automatic start();
    cs_o = 1'b0;
    #200;
  endtask
  // close the frame, then invert the data in line so it holds no stale level
  task automatic stop();
    #200;
    cs_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
  // one byte each way, msb first, 400 ns a bit so the core sees each phase
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      #200;
      rx[i] = sdo_oe_n_i ? ~sdo_i : sdo_i; // a released line reads inverted
      sclk_o = 1'b1;
      #200;
      sclk_o = 1'b0;
    end
  endtask
endmodule

// file: sim/tb.sv
// self-checking bench of the rate sensor host block
`include "gyro_defines.svh"
module tb
  import gyro_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic asel = 1'b0;
  logic sv = 1'b0;
  logic [15:0] temp = 16'h0000;
  logic cs, sclk, four_wire_data_in, four_wire_data_out, oe_n, tw_mode, cauto;
  logic [6:0] tw_addr;
  logic [2:0] st, lpf;
  logic [1:0] rng;
  logic [3:0] pmode;
  logic [7:0] rb;
  logic frame_sync_input = 1'b1; // frame sync held high so its fifo item is nonzero
  logic irq1, irq1_oe_n, irq2, irq2_oe_n;
  logic [7:0] pw [5] = '{8'h40, 8'h10, 8'h20, 8'h00, 8'h01}; // power control values
  logic [3:0] pm [5] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h4}; // one-hot mode each gives
  int errors = 0;
  int n_tests = 0;
  always #25 core_clk = ~core_clk;
  gyro_host_config_and_readout u_gyro_host_config_and_readout (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .chip_select_i(cs),
    .four_wire_clock_pin_i(sclk), .four_wire_data_in_i(four_wire_data_in),
    .address_select_pin_i(asel), .frame_sync_input_i(frame_sync_input),
    .four_wire_data_out_o(four_wire_data_out), .four_wire_data_out_oe_n_o(oe_n),
    .two_wire_mode_o(tw_mode), .two_wire_addr_o(tw_addr),
    .sample_valid_i(sv), .temp_i(temp), .rate_x_i(16'h0102),
    .rate_y_i(16'h0304), .rate_z_i(16'h0506), .self_test_o(st),
    .range_setting_o(rng), .low_pass_filter_stage_o(lpf), .clk_auto_o(cauto),
    .power_mode_o(pmode), .irq_out_primary_o(irq1), .irq_out_primary_oe_n_o(irq1_oe_n),
    .irq_out_secondary_o(irq2), .irq_out_secondary_oe_n_o(irq2_oe_n));
  host_model u_host_model (.cs_o(cs), .sclk_o(sclk), .sdi_o(four_wire_data_in), .sdo_i(four_wire_data_out),
    .sdo_oe_n_i(oe_n));
  // ==========
  // tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one framed command byte and one data byte, launched just after an edge
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] junk;
    @(posedge core_clk);
    #5;
    u_host_model.start();
    u_host_model.xbyte(c, junk);
    u_host_model.xbyte(d, rb);
    u_host_model.stop();
    repeat (6) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [15:0] t, input int n);
    @(posedge core_clk);
    #5 sv = 1'b1;
    temp = t;
    repeat (n) @(posedge core_clk);
    #5 sv = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    final_report();
  end
  // ==========
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    #5 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    chk("two wire mode", 8'(tw_mode), 8'h01);
    chk("address", 8'(tw_addr), 8'h68);
    chk("power mode", 8'(pmode), 8'(PM_SLEEP));
    xfer({1'b1, `OFS_IDENT}, 8'h00);
    chk("identity", rb, 8'h00);
    @(posedge core_clk);
    #5;
    u_host_model.start();
    repeat (8) @(posedge core_clk);
    chk("mode in frame", 8'(tw_mode), 8'h00);
    u_host_model.stop();
    $display("reset test done");
    xfer({1'b0, `OFS_POWER1}, `SOFT_RST_CMD);
    xfer({1'b1, `OFS_IDENT}, 8'h00);
    chk("identity", rb, `ID_VALUE);
    xfer({1'b0, `OFS_IDENT}, 8'h3C);
    xfer({1'b1, `OFS_IDENT}, 8'h00);
    chk("identity kept", rb, `ID_VALUE);
    $display("soft reset test done");
    xfer({1'b0, `OFS_RATE_DIV}, 8'h09);
    xfer({1'b0, `OFS_FILTER}, 8'h05);
    xfer({1'b0, `OFS_RANGE}, 8'hE8);
    chk("self test", 8'(st), 8'h07);
    chk("range", 8'(rng), 8'h01);
    chk("filter", 8'(lpf), 8'h05);
    xfer({1'b1, `OFS_RATE_DIV}, 8'h00);
    chk("divider", rb, 8'h09);
    xfer({1'b0, `OFS_RANGE}, 8'h00);
    chk("range", 8'(rng), 8'h00);
    $display("config test done");
    foreach (pw[i]) begin
      xfer({1'b0, `OFS_POWER1}, pw[i]);
      chk("power mode", 8'(pmode), 8'(pm[i]));
      chk("clock auto", 8'(cauto), 8'(pw[i][0]));
    end
    $display("power test done");
    @(posedge core_clk);
    #5 asel = 1'b1;
    repeat (5) @(posedge core_clk);
    chk("address", 8'(tw_addr), 8'h69);
    xfer({1'b0, `OFS_USER}, 8'h10);
    chk("two wire off", 8'(tw_mode), 8'h00);
    $display("address test done");
    xfer({1'b0, `OFS_RATE_DIV}, 8'h00);
    xfer({1'b0, `OFS_IRQ_EN1}, 8'h11);
    xfer({1'b0, `OFS_FIFO_SEL}, 8'h80);
    pulse(16'h1234, 1);
    #50 chk("irq primary", 8'(irq1), 8'h01);
    chk("irq drive", 8'({irq1_oe_n, irq2, irq2_oe_n}), 8'h00);
    xfer({1'b1, `OFS_TEMP_H}, 8'h00);
    chk("temperature", rb, 8'h12);
    xfer({1'b1, `OFS_CNT_L}, 8'h00);
    chk("fifo count", rb, 8'h02);
    xfer({1'b1, `OFS_IRQ_STAT}, 8'h00);
    chk("status", rb, 8'h01);
    @(posedge core_clk);
    #5;
    u_host_model.start();
    u_host_model.xbyte({1'b1, `OFS_FIFO_DATA}, rb);
    u_host_model.xbyte(8'h00, rb);
    chk("fifo high", rb, 8'h12);
    u_host_model.xbyte(8'h00, rb);
    chk("fifo low", rb, 8'h34);
    u_host_model.stop();
    xfer({1'b1, `OFS_CNT_L}, 8'h00);
    chk("fifo count", rb, 8'h00);
    xfer({1'b0, `OFS_FIFO_SEL}, 8'h08);
    pulse(16'h0000, 2);
    xfer({1'b1, `OFS_IRQ_STAT}, 8'h00);
    chk("overflow", rb, 8'h11);
    xfer({1'b1, `OFS_FIFO_DATA}, 8'h00);
    chk("sync high", rb, 8'h00);
    xfer({1'b1, `OFS_FIFO_DATA}, 8'h00);
    chk("sync low", rb, 8'h01);
    $display("sample test done");
    final_report();
  end
endmodule
